/* rtl/dgrec_top.sv */
// Diagnostic recorder: trace, calibration, counters, event log, output
`timescale 1ns/1ps
module dgrec_top #(
    parameter int TRACE_PERIOD = dgrec_pkg::TRACE_PERIOD_CYC,
    parameter longint HOUR_STEP = dgrec_pkg::HOUR_STEP_CYC,
    parameter int SEC_TICK = dgrec_pkg::SEC_CYC
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // Avalon-MM slave, word addressed
    input wire logic [dgrec_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Process inputs
    input wire logic sealing_impulse_bit_i,
    input wire logic supply_low_i,
    input wire logic [11:0] temp_actual_i,
    input wire logic [11:0] temp_setpoint_i,
    input wire logic fault_i,
    input wire logic [9:0] fault_code_i,
    input wire logic [11:0] fault_level_i,
    input wire logic zerocal_done_i,
    input wire logic baseline_cal_i,
    input wire logic [2:0] cal_channel_i,
    input wire logic [23:0] cal_raw_i,
    // Non-volatile counter image restored at power-up
    input wire logic nv_load_i,
    input wire logic [31:0] nv_cycles_i,
    input wire logic [31:0] nv_hours_i,
    // Outputs
    output logic standby_flag_o,
    output logic impulse_enable_o,
    output logic [11:0] actual_out_o,
    output logic nv_store_o,
    output logic [31:0] nv_cycles_o,
    output logic [31:0] nv_hours_o
);
    logic supply_low_s;
    logic st_s;
    logic st_d_reg;
    logic st_rise;
    logic zc_d_reg;
    logic bc_d_reg;
    logic zc_rise;
    logic bc_rise;
    logic flt_d_reg;
    logic flt_rise;

    dgrec_sync u_sync_low (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .async_i(supply_low_i),
        .sync_o(supply_low_s)
    );
    dgrec_sync u_sync_st (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .async_i(sealing_impulse_bit_i),
        .sync_o(st_s)
    );

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_d_reg <= 1'b0;
            zc_d_reg <= 1'b0;
            bc_d_reg <= 1'b0;
            flt_d_reg <= 1'b0;
        end
        else
        begin
            st_d_reg <= st_s;
            zc_d_reg <= zerocal_done_i;
            bc_d_reg <= baseline_cal_i;
            flt_d_reg <= fault_i;
        end
    end
    assign st_rise = st_s && !st_d_reg;
    assign zc_rise = zerocal_done_i && !zc_d_reg;
    assign bc_rise = baseline_cal_i && !bc_d_reg;
    assign flt_rise = fault_i && !flt_d_reg;

    // Control and configuration
    logic range500_reg;
    logic [15:0] passes_reg;
    logic bus_wr;
    logic bus_rd;
    assign bus_wr = avs_write_i && !avs_waitrequest_o;
    assign bus_rd = avs_read_i && avs_waitrequest_o;

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            range500_reg <= 1'b0;
            passes_reg <= dgrec_pkg::PASSES_RST;
        end
        else if (bus_wr && avs_address_i == dgrec_pkg::REG_CTRL)
            range500_reg <= avs_writedata_i[dgrec_pkg::CTRL_RANGE500];
        else if (bus_wr && avs_address_i == dgrec_pkg::REG_PASSES
                 && avs_writedata_i[15:0] != 16'h0000)
            passes_reg <= avs_writedata_i[15:0];
    end

    // Standby: inhibit impulses while supply is low
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            standby_flag_o <= 1'b1;
            impulse_enable_o <= 1'b0;
        end
        else
        begin
            standby_flag_o <= supply_low_s;
            impulse_enable_o <= !supply_low_s;
        end
    end

    // Actual-value output scaling
    logic [23:0] scaled;
    logic [11:0] range_sel;
    assign range_sel = range500_reg ? dgrec_pkg::RANGE_HI
                                    : dgrec_pkg::RANGE_LO;
    assign scaled = (temp_actual_i >= range_sel) ? {12'h000, dgrec_pkg::DAC_FULL}
        : ({12'h000, temp_actual_i} * 24'(dgrec_pkg::DAC_FULL))
          / {12'h000, range_sel};
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            actual_out_o <= 12'h000;
        else if (supply_low_s)
            actual_out_o <= 12'h000;
        else if (fault_i)
            actual_out_o <= fault_level_i;
        else
            actual_out_o <= scaled[11:0];
    end

    // Temperature trace; cleared memory is empty since reset
    logic [23:0] trace_mem [dgrec_pkg::TRACE_DEPTH];
    logic [dgrec_pkg::TRACE_AW-1:0] tr_wp_reg;
    logic [dgrec_pkg::TRACE_AW-1:0] tr_cnt_reg;
    logic [31:0] tr_tmr_reg;
    logic tr_first_reg;
    logic tr_clear_req;
    logic [dgrec_pkg::TRACE_AW-1:0] tr_idx_reg;
    assign tr_clear_req = bus_wr && avs_address_i == dgrec_pkg::REG_CTRL
        && avs_writedata_i[dgrec_pkg::CTRL_TRACE_CLR];

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            tr_wp_reg <= '0;
            tr_cnt_reg <= '0;
            tr_tmr_reg <= 32'h0;
            tr_first_reg <= 1'b0;
        end
        else if (tr_clear_req)
        begin
            tr_wp_reg <= '0;
            tr_cnt_reg <= '0;
            tr_tmr_reg <= 32'h0;
            tr_first_reg <= 1'b0;
        end
        else if (st_rise && !supply_low_s)
        begin
            tr_first_reg <= 1'b1;
            tr_tmr_reg <= 32'h0;
        end
        else if (st_s && !supply_low_s && tr_cnt_reg !=
                 dgrec_pkg::TRACE_AW'(dgrec_pkg::TRACE_DEPTH))
        begin
            if (tr_tmr_reg == 32'h0)
            begin
                tr_wp_reg <= tr_wp_reg + 1'b1;
                tr_cnt_reg <= tr_cnt_reg + 1'b1;
                tr_first_reg <= 1'b0;
            end
            tr_tmr_reg <= (tr_tmr_reg == 32'(TRACE_PERIOD - 1)) ? 32'h0
                                                   : tr_tmr_reg + 32'h1;
        end
    end
    always_ff @(posedge ref_clk_i)
    begin
        if (st_s && !supply_low_s && !st_rise && !tr_clear_req
            && tr_tmr_reg == 32'h0 && tr_cnt_reg !=
            dgrec_pkg::TRACE_AW'(dgrec_pkg::TRACE_DEPTH))
            trace_mem[tr_wp_reg] <= {tr_first_reg ?
                12'(-$signed(temp_setpoint_i)) : temp_setpoint_i,
                temp_actual_i};
    end

    // Calibration per channel
    logic [23:0] cal_abs_reg [dgrec_pkg::N_CH];
    logic [23:0] cal_base_reg [dgrec_pkg::N_CH];
    logic [15:0] cal_dev_reg [dgrec_pkg::N_CH];
    logic [2:0] cal_sel_reg;
    logic [39:0] abs_scaled;
    logic [31:0] dev_calc;
    assign abs_scaled = {16'h0000, cal_raw_i} * {24'h0, passes_reg};
    assign dev_calc = (cal_base_reg[cal_channel_i] == 24'h0) ? 32'h0 :
        32'(($signed({17'h0, cal_raw_i})
            - $signed({17'h0, cal_base_reg[cal_channel_i]})) * 41'sd1000
            / $signed({17'h0, cal_base_reg[cal_channel_i]}));
    genvar g;
    generate
        for (g = 0; g < dgrec_pkg::N_CH; g++)
        begin : g_cal
            always_ff @(posedge ref_clk_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                begin
                    cal_abs_reg[g] <= 24'h0;
                    cal_base_reg[g] <= 24'h0;
                    cal_dev_reg[g] <= 16'h0;
                end
                else if (cal_channel_i == 3'(g))
                begin
                    if (bc_rise)
                        cal_base_reg[g] <= cal_raw_i;
                    if (zc_rise)
                    begin
                        cal_abs_reg[g] <= abs_scaled[23:0];
                        cal_dev_reg[g] <= dev_calc[15:0];
                    end
                end
            end
        end
    endgenerate

    // Counters; nv image restored and stored externally
    logic [31:0] cycles_reg;
    logic [31:0] hours_reg;
    logic [63:0] hr_tmr_reg;
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cycles_reg <= 32'h0;
            hours_reg <= 32'h0;
            hr_tmr_reg <= 64'h0;
            nv_store_o <= 1'b0;
        end
        else if (nv_load_i)
        begin
            cycles_reg <= nv_cycles_i;
            hours_reg <= nv_hours_i;
            nv_store_o <= 1'b0;
        end
        else
        begin
            nv_store_o <= 1'b0;
            if (st_rise && !supply_low_s)
            begin
                cycles_reg <= cycles_reg + 32'h1;
                nv_store_o <= 1'b1;
            end
            if (hr_tmr_reg == 64'(HOUR_STEP - 1))
            begin
                hr_tmr_reg <= 64'h0;
                hours_reg <= hours_reg + 32'h1;
                nv_store_o <= 1'b1;
            end
            else
                hr_tmr_reg <= hr_tmr_reg + 64'h1;
        end
    end
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            nv_cycles_o <= 32'h0;
            nv_hours_o <= 32'h0;
        end
        else
        begin
            nv_cycles_o <= cycles_reg;
            nv_hours_o <= hours_reg;
        end
    end

    // Built-in clock, seconds since epoch
    logic [31:0] clk_sec_reg;
    logic [31:0] clk_tmr_reg;
    logic clk_valid_reg;
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            clk_sec_reg <= 32'h0;
            clk_tmr_reg <= 32'h0;
            clk_valid_reg <= 1'b0;
        end
        else if (bus_wr && avs_address_i == dgrec_pkg::REG_CLOCK)
        begin
            clk_sec_reg <= avs_writedata_i;
            clk_tmr_reg <= 32'h0;
            clk_valid_reg <= 1'b1;
        end
        else if (clk_tmr_reg == 32'(SEC_TICK - 1))
        begin
            clk_tmr_reg <= 32'h0;
            clk_sec_reg <= clk_sec_reg + 32'h1;
        end
        else
            clk_tmr_reg <= clk_tmr_reg + 32'h1;
    end

    // Event log, circular; newest at read index 0
    logic [15:0] log_evt [dgrec_pkg::LOG_DEPTH];
    logic [32:0] log_ts [dgrec_pkg::LOG_DEPTH];
    logic [dgrec_pkg::LOG_AW-1:0] log_wp_reg;
    logic [dgrec_pkg::LOG_AW-1:0] log_cnt_reg;
    logic [dgrec_pkg::LOG_AW-1:0] log_idx_reg;
    logic log_ev;
    logic [15:0] log_word;
    logic clk_set_ev;
    assign clk_set_ev = bus_wr && avs_address_i == dgrec_pkg::REG_CLOCK;
    assign log_ev = flt_rise || zc_rise || clk_set_ev;
    always_comb
    begin
        if (flt_rise)
            log_word = {dgrec_pkg::DGREC_EV_ALARM, 4'h0, fault_code_i};
        else if (zc_rise)
            log_word = {dgrec_pkg::DGREC_EV_ZEROCAL, 1'b0, cal_channel_i,
                        10'h000};
        else
            log_word = {dgrec_pkg::DGREC_EV_CLKSET, 14'h0000};
    end
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            log_wp_reg <= '0;
            log_cnt_reg <= '0;
        end
        else if (log_ev)
        begin
            log_wp_reg <= (log_wp_reg == dgrec_pkg::LOG_AW'(
                dgrec_pkg::LOG_DEPTH - 1)) ? '0
                : log_wp_reg + 1'b1;
            if (log_cnt_reg != dgrec_pkg::LOG_AW'(dgrec_pkg::LOG_DEPTH))
                log_cnt_reg <= log_cnt_reg + 1'b1;
        end
    end
    always_ff @(posedge ref_clk_i)
    begin
        if (log_ev)
        begin
            log_evt[log_wp_reg] <= log_word;
            log_ts[log_wp_reg] <= {clk_valid_reg, clk_sec_reg};
        end
    end
    logic [dgrec_pkg::LOG_AW:0] log_rd_sum;
    logic [dgrec_pkg::LOG_AW-1:0] log_rd;
    assign log_rd_sum = {1'b0, log_wp_reg} + (dgrec_pkg::LOG_AW + 1)'(
        dgrec_pkg::LOG_DEPTH - 1) - {1'b0, log_idx_reg};
    assign log_rd = (log_rd_sum >= (dgrec_pkg::LOG_AW + 1)'(
        dgrec_pkg::LOG_DEPTH)) ? dgrec_pkg::LOG_AW'(log_rd_sum -
        (dgrec_pkg::LOG_AW + 1)'(dgrec_pkg::LOG_DEPTH))
        : log_rd_sum[dgrec_pkg::LOG_AW-1:0];

    // Index registers
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cal_sel_reg <= 3'h0;
            tr_idx_reg <= '0;
            log_idx_reg <= '0;
        end
        else if (bus_wr)
        begin
            if (avs_address_i == dgrec_pkg::REG_CAL_SEL)
                cal_sel_reg <= avs_writedata_i[2:0];
            if (avs_address_i == dgrec_pkg::REG_TRACE_IDX)
                tr_idx_reg <= avs_writedata_i[dgrec_pkg::TRACE_AW-1:0];
            if (avs_address_i == dgrec_pkg::REG_LOG_IDX && avs_writedata_i <
                32'(dgrec_pkg::LOG_DEPTH))
                log_idx_reg <= avs_writedata_i[dgrec_pkg::LOG_AW-1:0];
        end
    end

    // Bus answer: one wait cycle, then data with waitrequest low
    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = 32'h0;
        unique case (avs_address_i)
            dgrec_pkg::REG_CTRL:
                rd_mux = {30'h0, range500_reg, 1'b0};
            dgrec_pkg::REG_STATUS:
                rd_mux = {28'h0, 1'b0, st_s, clk_valid_reg, standby_flag_o};
            dgrec_pkg::REG_PASSES: rd_mux = {16'h0, passes_reg};
            dgrec_pkg::REG_CLOCK: rd_mux = clk_sec_reg;
            dgrec_pkg::REG_CYCLES: rd_mux = cycles_reg;
            dgrec_pkg::REG_HOURS: rd_mux = hours_reg;
            dgrec_pkg::REG_CAL_SEL: rd_mux = {29'h0, cal_sel_reg};
            dgrec_pkg::REG_CAL_ABS: rd_mux = {8'h0, cal_abs_reg[cal_sel_reg]};
            dgrec_pkg::REG_CAL_BASE:
                rd_mux = {8'h0, cal_base_reg[cal_sel_reg]};
            dgrec_pkg::REG_CAL_DEV: rd_mux = {16'h0, cal_dev_reg[cal_sel_reg]};
            dgrec_pkg::REG_TRACE_IDX:
                rd_mux = {23'h0, tr_cnt_reg};
            dgrec_pkg::REG_TRACE_DAT:
                rd_mux = (tr_idx_reg < tr_cnt_reg) ?
                    {8'h0, trace_mem[tr_idx_reg]} : 32'h0;
            dgrec_pkg::REG_LOG_IDX: rd_mux = {23'h0, log_cnt_reg};
            dgrec_pkg::REG_LOG_EVT:
                rd_mux = (log_idx_reg < log_cnt_reg) ?
                    {16'h0, log_evt[log_rd]} : 32'h0;
            dgrec_pkg::REG_LOG_TIME:
                rd_mux = (log_idx_reg < log_cnt_reg) ?
                    log_ts[log_rd][31:0] : 32'h0;
            default: rd_mux = 32'h0;
        endcase
    end
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= 32'h0;
        end
        else
        begin
            avs_waitrequest_o <= !((avs_read_i || avs_write_i)
                                   && avs_waitrequest_o);
            if (bus_rd)
                avs_readdata_o <= rd_mux;
        end
    end
endmodule : dgrec_top

/* rtl/dgrec_pkg.sv */
// Constants, register map and types of the diagnostic recorder
package dgrec_pkg;
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h1;
    localparam logic [ADDR_W-1:0] REG_PASSES = 4'h2;
    localparam logic [ADDR_W-1:0] REG_CLOCK = 4'h3;
    localparam logic [ADDR_W-1:0] REG_CYCLES = 4'h4;
    localparam logic [ADDR_W-1:0] REG_HOURS = 4'h5;
    localparam logic [ADDR_W-1:0] REG_CAL_SEL = 4'h6;
    localparam logic [ADDR_W-1:0] REG_CAL_ABS = 4'h7;
    localparam logic [ADDR_W-1:0] REG_CAL_BASE = 4'h8;
    localparam logic [ADDR_W-1:0] REG_CAL_DEV = 4'h9;
    localparam logic [ADDR_W-1:0] REG_TRACE_IDX = 4'ha;
    localparam logic [ADDR_W-1:0] REG_TRACE_DAT = 4'hb;
    localparam logic [ADDR_W-1:0] REG_LOG_IDX = 4'hc;
    localparam logic [ADDR_W-1:0] REG_LOG_EVT = 4'hd;
    localparam logic [ADDR_W-1:0] REG_LOG_TIME = 4'he;
    // Control bits
    localparam int CTRL_TRACE_CLR = 0;
    localparam int CTRL_RANGE500 = 1;
    localparam int CTRL_CLK_SET = 2;
    // Status bits
    localparam int ST_STANDBY = 0;
    localparam int ST_CLK_VALID = 1;
    localparam int ST_TRACE_BUSY = 2;
    localparam int ST_CLEARING = 3;
    localparam int N_CH = 8;
    localparam int CH_W = 3;
    localparam int TRACE_DEPTH = 500;
    localparam int TRACE_AW = 9;
    localparam int LOG_DEPTH = 400;
    localparam int LOG_AW = 9;
    localparam int TEMP_W = 12;
    localparam int DAC_W = 12;
    localparam logic [DAC_W-1:0] DAC_FULL = 12'hfff;
    localparam logic [TEMP_W-1:0] RANGE_LO = 12'h12c;
    localparam logic [TEMP_W-1:0] RANGE_HI = 12'h1f4;
    localparam logic [15:0] PASSES_RST = 16'h0001;
    // Trace sample period: 5 s across the trace depth
    localparam int CLK_MHZ = 250;
    localparam int TRACE_SPAN_MS = 5000;
    localparam int TRACE_PERIOD_CYC =
        (TRACE_SPAN_MS / TRACE_DEPTH) * CLK_MHZ * 1000;
    localparam int HOUR_STEP_MIN = 6;
    localparam longint HOUR_STEP_CYC =
        longint'(HOUR_STEP_MIN) * 60 * CLK_MHZ * 1000000;
    localparam int SEC_CYC = CLK_MHZ * 1000000;
    typedef enum logic [1:0] {
        DGREC_EV_ALARM,
        DGREC_EV_ZEROCAL,
        DGREC_EV_CLKSET
    } dgrec_event_e;
endpackage : dgrec_pkg

/* rtl/dgrec_sync.sv */
// Three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module dgrec_sync (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic async_i,
    output logic sync_o
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            sync_o <= 1'b0;
        end
        else
        begin
            s1_reg <= async_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            // Change counts only once two stages agree
            if (s2_reg == s3_reg)
                sync_o <= s3_reg;
        end
    end
endmodule : dgrec_sync

/* verif/dgrec_assertions.sv */
// Port checker for the diagnostic recorder
`timescale 1ns/1ps
module dgrec_assertions (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic avs_waitrequest_o,
    input wire logic supply_low_i,
    input wire logic fault_i,
    input wire logic [11:0] fault_level_i,
    input wire logic nv_load_i,
    input wire logic standby_flag_o,
    input wire logic impulse_enable_o,
    input wire logic [11:0] actual_out_o,
    input wire logic nv_store_o,
    input wire logic [31:0] nv_cycles_o,
    input wire logic [31:0] nv_hours_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    // Eight cycles covers the filtered synchroniser latency
    standby_enter_a: assert property (supply_low_i [*8] |-> standby_flag_o)
        else $error("standby flag not set");
    standby_leave_a: assert property (!supply_low_i [*8] |-> !standby_flag_o)
        else $error("standby flag not cleared");
    standby_out_a: assert property (standby_flag_o [*2] |-> actual_out_o == 12'h000)
        else $error("output not zero in standby");
    impulse_block_a: assert property (standby_flag_o [*2] |-> !impulse_enable_o)
        else $error("impulses not inhibited");
    fault_level_a: assert property ((!standby_flag_o && fault_i && $stable(fault_level_i)) [*3] |-> actual_out_o == fault_level_i)
        else $error("fault level not on output");
    bus_answer_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("bus answer late");
    bus_single_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("answer held too long");
    cycles_step_a: assert property ($changed(nv_cycles_o) && !$past(nv_load_i, 2) |-> nv_cycles_o == $past(nv_cycles_o) + 32'h1)
        else $error("cycle counter jumped");
    hours_step_a: assert property ($changed(nv_hours_o) && !$past(nv_load_i, 2) |-> nv_hours_o == $past(nv_hours_o) + 32'h1)
        else $error("hours counter jumped");
    nv_store_a: assert property ($changed(nv_cycles_o) && !$past(nv_load_i, 2) |-> $past(nv_store_o))
        else $error("counter change not stored");
    cover property (standby_flag_o ##1 !standby_flag_o);
    cover property ($rose(fault_i));
    cover property ($rose(nv_store_o));
endmodule : dgrec_assertions

bind dgrec_top dgrec_assertions chk_u (.*);

/* verif/dgrec_host.sv */
// Avalon-MM master standing in for the fieldbus controller
`timescale 1ns/1ps
module dgrec_host (
    input wire logic clk_i,
    input wire logic wait_i,
    input wire logic [31:0] rdata_i,
    output logic [3:0] addr_o,
    output logic rd_o,
    output logic wr_o,
    output logic [31:0] wdata_o
);
    initial
    begin
        addr_o = 4'h0;
        rd_o = 1'b0;
        wr_o = 1'b0;
        wdata_o = 32'h0;
    end
    // Waits for the answer; only the bench watchdog ends a hang
    task xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
              output logic [31:0] q);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        rd_o <= !w;
        wr_o <= w;
        @(posedge clk_i);
        while (wait_i !== 1'b0)
            @(posedge clk_i);
        q = rdata_i;
        rd_o <= 1'b0;
        wr_o <= 1'b0;
    endtask : xfer
endmodule : dgrec_host

/* verif/dgrec_top_bench.sv */
// Self-checking bench for the diagnostic recorder
`timescale 1ns/1ps
module dgrec_top_bench;
    logic ref_clk_i, rst_n_i, avs_read_i, avs_write_i, avs_waitrequest_o;
    logic [3:0] avs_address_i;
    logic [31:0] avs_writedata_i, avs_readdata_o, q, h;
    logic sealing_impulse_bit_i, supply_low_i, fault_i, zerocal_done_i;
    logic baseline_cal_i, nv_load_i, standby_flag_o, impulse_enable_o;
    logic nv_store_o;
    logic [11:0] temp_actual_i, temp_setpoint_i, fault_level_i, actual_out_o;
    logic [9:0] fault_code_i;
    logic [2:0] cal_channel_i;
    logic [23:0] cal_raw_i;
    logic [31:0] nv_cycles_i, nv_hours_i, nv_cycles_o, nv_hours_o;
    int failures, n_compared;
    // Short counts keep the run brief
    dgrec_top #(.TRACE_PERIOD(4), .HOUR_STEP(20), .SEC_TICK(10)) dut_u (.*);
    dgrec_host host_u (
        .clk_i(ref_clk_i),
        .wait_i(avs_waitrequest_o),
        .rdata_i(avs_readdata_o),
        .addr_o(avs_address_i),
        .rd_o(avs_read_i),
        .wr_o(avs_write_i),
        .wdata_o(avs_writedata_i)
    );
    initial
    begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end
    task finish_test;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : finish_test
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            failures++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask : cyc
    task wr(input logic [3:0] a, input logic [31:0] d);
        host_u.xfer(1'b1, a, d, q);
    endtask : wr
    task rc(input logic [3:0] a, input logic [31:0] e, input string nm);
        host_u.xfer(1'b0, a, 32'h0, q);
        chk(nm, e, q);
    endtask : rc
    task t_trace;
        @(posedge ref_clk_i);
        temp_setpoint_i <= 12'h064;
        temp_actual_i <= 12'h032;
        sealing_impulse_bit_i <= 1'b1;
        cyc(2200);
        sealing_impulse_bit_i <= 1'b0;
        cyc(10);
        rc(dgrec_pkg::REG_TRACE_IDX, 32'h1f4, "trace count");
        wr(dgrec_pkg::REG_TRACE_IDX, 32'h0);
        rc(dgrec_pkg::REG_TRACE_DAT, 32'h00f9c032, "first sample");
        wr(dgrec_pkg::REG_TRACE_IDX, 32'h1);
        rc(dgrec_pkg::REG_TRACE_DAT, 32'h00064032, "next sample");
        rc(dgrec_pkg::REG_CYCLES, 32'h11, "cycles");
        wr(dgrec_pkg::REG_CYCLES, 32'h0);
        rc(dgrec_pkg::REG_CYCLES, 32'h11, "cycles ro");
        wr(dgrec_pkg::REG_CTRL, 32'h1);
        cyc(600);
        rc(dgrec_pkg::REG_TRACE_IDX, 32'h0, "trace cleared");
    endtask : t_trace
    task cal(input logic base, input logic [23:0] raw);
        @(posedge ref_clk_i);
        cal_channel_i <= 3'h3;
        cal_raw_i <= raw;
        baseline_cal_i <= base;
        zerocal_done_i <= !base;
        cyc(2);
        baseline_cal_i <= 1'b0;
        zerocal_done_i <= 1'b0;
        cyc(6);
    endtask : cal
    task t_cal;
        rc(dgrec_pkg::REG_PASSES, 32'h1, "passes reset");
        cal(1'b1, 24'h3e8);
        wr(dgrec_pkg::REG_CAL_SEL, 32'h3);
        rc(dgrec_pkg::REG_CAL_BASE, 32'h3e8, "base");
        cal(1'b0, 24'h44c);
        rc(dgrec_pkg::REG_CAL_ABS, 32'h44c, "abs");
        rc(dgrec_pkg::REG_CAL_DEV, 32'h64, "deviation");
        rc(dgrec_pkg::REG_CAL_BASE, 32'h3e8, "base kept");
        wr(dgrec_pkg::REG_PASSES, 32'h2);
        wr(dgrec_pkg::REG_PASSES, 32'h0);
        rc(dgrec_pkg::REG_PASSES, 32'h2, "passes");
        cal(1'b0, 24'h44c);
        rc(dgrec_pkg::REG_CAL_DEV, 32'h64, "dev unscaled");
        rc(dgrec_pkg::REG_CAL_ABS, 32'h898, "abs scaled");
        wr(dgrec_pkg::REG_CAL_SEL, 32'h5);
        rc(dgrec_pkg::REG_CAL_ABS, 32'h0, "other channel");
    endtask : t_cal
    task t_log;
        wr(dgrec_pkg::REG_CLOCK, 32'h3e8);
        host_u.xfer(1'b0, dgrec_pkg::REG_STATUS, 32'h0, q);
        chk("clock valid", 32'h1, {31'h0, q[1]});
        for (int i = 1; i <= 401; i++)
        begin
            @(posedge ref_clk_i);
            fault_code_i <= 10'(i);
            fault_level_i <= 12'(i);
            fault_i <= 1'b1;
            cyc(5);
            if (i == 1)
                chk("fault out", 32'h1, {20'h0, actual_out_o});
            fault_i <= 1'b0;
            cyc(2);
        end
        chk("control on", 32'h1, {31'h0, impulse_enable_o});
        rc(dgrec_pkg::REG_LOG_IDX, 32'h190, "log count");
        wr(dgrec_pkg::REG_LOG_IDX, 32'h0);
        host_u.xfer(1'b0, dgrec_pkg::REG_LOG_EVT, 32'h0, q);
        chk("evt type", 32'(dgrec_pkg::DGREC_EV_ALARM), {30'h0, q[15:14]});
        chk("newest", 32'h191, {22'h0, q[9:0]});
        host_u.xfer(1'b0, dgrec_pkg::REG_LOG_TIME, 32'h0, q);
        chk("stamp", 32'h1, {31'h0, q >= 32'h3e8});
        wr(dgrec_pkg::REG_LOG_IDX, 32'h18f);
        host_u.xfer(1'b0, dgrec_pkg::REG_LOG_EVT, 32'h0, q);
        chk("oldest", 32'h2, {22'h0, q[9:0]});
        wr(dgrec_pkg::REG_LOG_IDX, 32'h190);
        host_u.xfer(1'b0, dgrec_pkg::REG_LOG_EVT, 32'h0, q);
        chk("index refused", 32'h2, {22'h0, q[9:0]});
        host_u.xfer(1'b0, dgrec_pkg::REG_CLOCK, 32'h0, q);
        chk("clock read", 32'h1, {31'h0, q >= 32'h3e8});
    endtask : t_log
    task sc(input logic r, input logic [11:0] t, input logic [11:0] e);
        wr(dgrec_pkg::REG_CTRL, {30'h0, r, 1'b0});
        @(posedge ref_clk_i);
        temp_actual_i <= t;
        cyc(6);
        chk("scale", {20'h0, e}, {20'h0, actual_out_o});
    endtask : sc
    task t_standby;
        @(posedge ref_clk_i);
        supply_low_i <= 1'b1;
        cyc(12);
        chk("standby", 32'h1, {31'h0, standby_flag_o});
        chk("inhibit", 32'h0, {31'h0, impulse_enable_o});
        chk("zero out", 32'h0, {20'h0, actual_out_o});
        host_u.xfer(1'b0, dgrec_pkg::REG_STATUS, 32'h0, q);
        chk("status sb", 32'h1, {31'h0, q[0]});
        supply_low_i <= 1'b0;
        cyc(12);
        chk("resume", 32'h1, {31'h0, impulse_enable_o});
    endtask : t_standby
    task t_hours;
        host_u.xfer(1'b0, dgrec_pkg::REG_HOURS, 32'h0, h);
        wr(dgrec_pkg::REG_HOURS, 32'h0);
        cyc(195);
        host_u.xfer(1'b0, dgrec_pkg::REG_HOURS, 32'h0, q);
        chk("hours", 32'h1, {31'h0, (q - h) == 32'ha || (q - h) == 32'hb});
    endtask : t_hours
    initial
    begin
        #100000;
        failures++;
        $display("[ERR] watchdog exp done got timeout");
        finish_test();
    end
    initial
    begin
        {rst_n_i, sealing_impulse_bit_i, supply_low_i, fault_i} = 4'h0;
        {zerocal_done_i, baseline_cal_i, nv_load_i} = 3'h0;
        {temp_actual_i, temp_setpoint_i, fault_level_i} = 36'h0;
        fault_code_i = 10'h0;
        cal_channel_i = 3'h0;
        cal_raw_i = 24'h0;
        nv_cycles_i = 32'h10;
        nv_hours_i = 32'h5;
        cyc(3);
        chk("reset standby", 32'h1, {31'h0, standby_flag_o});
        rst_n_i <= 1'b1;
        nv_load_i <= 1'b1;
        cyc(1);
        nv_load_i <= 1'b0;
        cyc(12);
        chk("enable", 32'h1, {31'h0, impulse_enable_o});
        rc(4'hf, 32'h0, "unmapped");
        t_trace();
        t_cal();
        sc(1'b0, 12'h064, 12'h555);
        sc(1'b0, 12'h12c, 12'hfff);
        sc(1'b1, 12'h064, 12'h333);
        sc(1'b1, 12'h1f4, 12'hfff);
        sc(1'b0, 12'h000, 12'h000);
        t_standby();
        t_hours();
        t_log();
        finish_test();
    end
endmodule : dgrec_top_bench
